// ---- hdl/osc_cfg_pkg.sv ----
package osc_cfg_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Field positions in the configuration byte
  localparam int SWMON_HI = 7;
  localparam int SWMON_LO = 6;
  localparam int SOSC_BIT = 5;
  localparam int FREQ_HI = 4;
  localparam int FREQ_LO = 3;
  localparam int CLKOUT_BIT = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;

  // Erased configuration byte: all ones
  localparam logic [7:0] CONFIG_RESET = 8'hFF;

  // Status register bit positions
  localparam int ST_SWITCH = 0;
  localparam int ST_MONITOR = 1;
  localparam int ST_SOSC_HP = 2;
  localparam int ST_CLKOUT = 3;
  localparam int ST_FREQ_BAD = 4;
  localparam int ST_RANGE_LO = 5;
  localparam int ST_MODE_LO = 8;

  // Primary oscillator field values
  localparam logic [1:0] MODE_OFF = 2'h3;
  localparam logic [1:0] MODE_HS = 2'h2;
  localparam logic [1:0] MODE_XT = 2'h1;
  localparam logic [1:0] MODE_EXT = 2'h0;

  // Frequency range field values
  localparam logic [1:0] FREQ_HIGH = 2'h3;
  localparam logic [1:0] FREQ_MID = 2'h2;
  localparam logic [1:0] FREQ_LOW = 2'h1;
  localparam logic [1:0] FREQ_RSVD = 2'h0;

  typedef enum logic [1:0] {
    range_reserved,
    range_below_100k,
    range_100k_to_8m,
    range_above_8m
  } freq_range_t;

  typedef enum logic [1:0] {
    osc_external_clock_input,
    osc_standard_crystal,
    osc_high_speed_crystal,
    osc_disabled
  } osc_mode_t;

  typedef struct packed {
    logic switch_enable;
    logic monitor_enable;
    logic sosc_high_power;
    logic clock_out_enable;
    logic freq_reserved;
    freq_range_t freq_range;
    osc_mode_t primary_osc_mode;
  } osc_settings_t;

endpackage

// ---- hdl/osc_field_decode.sv ----
`timescale 1ns/1ps
module osc_field_decode
(
  // Raw configuration byte
  input wire logic [7:0] config_byte,
  // Decoded settings
  output osc_cfg_pkg::osc_settings_t settings
);

  logic [1:0] swmon;
  logic [1:0] freq;
  logic [1:0] mode;

  always_comb
  begin
    swmon = config_byte[osc_cfg_pkg::SWMON_HI:osc_cfg_pkg::SWMON_LO];
    freq = config_byte[osc_cfg_pkg::FREQ_HI:osc_cfg_pkg::FREQ_LO];
    mode = config_byte[osc_cfg_pkg::MODE_HI:osc_cfg_pkg::MODE_LO];
    settings.switch_enable = ~swmon[1]; // [R01]
    settings.monitor_enable = (swmon == 2'h0); // [R01]
    settings.sosc_high_power = config_byte[osc_cfg_pkg::SOSC_BIT]; // [R02]
    settings.freq_reserved = (freq == osc_cfg_pkg::FREQ_RSVD); // [R03]
    case (freq)
      osc_cfg_pkg::FREQ_HIGH: settings.freq_range = osc_cfg_pkg::range_above_8m; // [R03]
      osc_cfg_pkg::FREQ_MID: settings.freq_range = osc_cfg_pkg::range_100k_to_8m; // [R03]
      osc_cfg_pkg::FREQ_LOW: settings.freq_range = osc_cfg_pkg::range_below_100k; // [R03]
      default: settings.freq_range = osc_cfg_pkg::range_reserved;
    endcase
    case (mode)
      osc_cfg_pkg::MODE_OFF: settings.primary_osc_mode = osc_cfg_pkg::osc_disabled; // [R05]
      osc_cfg_pkg::MODE_HS: settings.primary_osc_mode = osc_cfg_pkg::osc_high_speed_crystal; // [R05]
      osc_cfg_pkg::MODE_XT: settings.primary_osc_mode = osc_cfg_pkg::osc_standard_crystal; // [R05]
      default: settings.primary_osc_mode = osc_cfg_pkg::osc_external_clock_input; // [R05]
    endcase
    // Crystal modes own the output pin, so no clock output then
    settings.clock_out_enable = config_byte[osc_cfg_pkg::CLKOUT_BIT]
      && (mode == osc_cfg_pkg::MODE_OFF || mode == osc_cfg_pkg::MODE_EXT); // [R04]
  end

endmodule // osc_field_decode

// ---- hdl/oscillator_config_decode.sv ----
// Contract
// (R01) Switch/monitor field: 1x none, 01 switch, 00 both
// (R02) Bit 5 selects secondary oscillator high power
// (R03) Frequency range field; 00 is reserved
// (R04) Bit 2 drives clock output if mode 11/00
// (R05) Mode field: off, high-speed, standard, external clock
`timescale 1ns/1ps
module oscillator_config_decode
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded clock controls
  output logic switch_enable,
  output logic monitor_enable,
  output logic sosc_high_power,
  output logic [1:0] primary_freq_range,
  output logic [1:0] primary_osc_mode,
  output logic clock_output_signal_enable
);

  // Bus phases
  logic setup_phase;
  logic access_phase;
  // Address decode
  logic hit_config;
  logic hit_status;
  logic hit_none;
  // Configuration byte
  logic [7:0] config_r;
  logic [7:0] config_nxt;
  // Bus response
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic pready_r;
  logic pready_nxt;
  // Decoded byte and the registered controls
  osc_cfg_pkg::osc_settings_t decoded;
  logic switch_r;
  logic switch_nxt;
  logic monitor_r;
  logic monitor_nxt;
  logic sosc_r;
  logic sosc_nxt;
  logic clkout_r;
  logic clkout_nxt;
  logic freq_bad_r;
  logic freq_bad_nxt;
  osc_cfg_pkg::freq_range_t range_r;
  osc_cfg_pkg::freq_range_t range_nxt;
  osc_cfg_pkg::osc_mode_t mode_r;
  osc_cfg_pkg::osc_mode_t mode_nxt;
  // Read-only view of the controls
  logic [31:0] status;

  osc_field_decode u_decode
  (
    .config_byte(config_r),
    .settings(decoded)
  );

  // Bus phases
  always_comb
  begin
    setup_phase = psel && !penable;
    access_phase = psel && penable;
  end

  // Address decode
  always_comb
  begin
    hit_config = 1'b0;
    hit_status = 1'b0;
    hit_none = 1'b0;
    if (paddr == osc_cfg_pkg::ADDR_CONFIG)
    begin
      hit_config = 1'b1;
    end
    else if (paddr == osc_cfg_pkg::ADDR_STATUS)
    begin
      hit_status = 1'b1;
    end
    else
    begin
      hit_none = 1'b1;
    end
  end

  // Configuration byte: only a write in the access phase changes it
  always_comb
  begin
    config_nxt = config_r;
    if (access_phase && pwrite && hit_config)
    begin
      config_nxt = pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      config_r <= osc_cfg_pkg::CONFIG_RESET;
    end
    else
    begin
      config_r <= config_nxt;
    end
  end

  // Bus response: captured in the setup phase, held through the access phase
  always_comb
  begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = 1'b1;
    if (setup_phase)
    begin
      if (hit_config)
      begin
        prdata_nxt = {24'h00_0000, config_r};
      end
      else if (hit_status)
      begin
        prdata_nxt = status;
        pslverr_nxt = pwrite;
      end
      else
      begin
        pslverr_nxt = 1'b1;
      end
    end
    else if (access_phase)
    begin
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pready_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      pready_r <= pready_nxt;
    end
  end

  // Clock switching permission
  always_comb
  begin
    switch_nxt = decoded.switch_enable; // [R01]
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      switch_r <= 1'b0;
    end
    else
    begin
      switch_r <= switch_nxt;
    end
  end

  // Fail-safe monitor permission
  always_comb
  begin
    monitor_nxt = decoded.monitor_enable; // [R01]
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      monitor_r <= 1'b0;
    end
    else
    begin
      monitor_r <= monitor_nxt;
    end
  end

  // Secondary oscillator power level
  always_comb
  begin
    sosc_nxt = decoded.sosc_high_power; // [R02]
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sosc_r <= 1'b0;
    end
    else
    begin
      sosc_r <= sosc_nxt;
    end
  end

  // Clock output on the oscillator output pin
  always_comb
  begin
    clkout_nxt = decoded.clock_out_enable; // [R04]
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clkout_r <= 1'b0;
    end
    else
    begin
      clkout_r <= clkout_nxt;
    end
  end

  // Reserved range code seen in the byte
  always_comb
  begin
    freq_bad_nxt = decoded.freq_reserved; // [R03]
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      freq_bad_r <= 1'b0;
    end
    else
    begin
      freq_bad_r <= freq_bad_nxt;
    end
  end

  // Range: a reserved code leaves the range in force
  always_comb
  begin
    range_nxt = decoded.freq_range; // [R03]
    if (decoded.freq_reserved)
    begin
      range_nxt = range_r; // [R03]
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      range_r <= osc_cfg_pkg::range_reserved;
    end
    else
    begin
      range_r <= range_nxt;
    end
  end

  // Primary oscillator mode
  always_comb
  begin
    mode_nxt = decoded.primary_osc_mode; // [R05]
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_r <= osc_cfg_pkg::osc_external_clock_input;
    end
    else
    begin
      mode_r <= mode_nxt;
    end
  end

  // Status word
  always_comb
  begin
    status = 32'h0000_0000;
    status[osc_cfg_pkg::ST_SWITCH] = switch_r;
    status[osc_cfg_pkg::ST_MONITOR] = monitor_r;
    status[osc_cfg_pkg::ST_SOSC_HP] = sosc_r;
    status[osc_cfg_pkg::ST_CLKOUT] = clkout_r;
    status[osc_cfg_pkg::ST_FREQ_BAD] = freq_bad_r;
    status[osc_cfg_pkg::ST_RANGE_LO +: 2] = range_r;
    status[osc_cfg_pkg::ST_MODE_LO +: 2] = mode_r;
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign switch_enable = switch_r; // [R01]
  assign monitor_enable = monitor_r; // [R01]
  assign sosc_high_power = sosc_r; // [R02]
  assign primary_freq_range = range_r; // [R03]
  assign primary_osc_mode = mode_r; // [R05]
  assign clock_output_signal_enable = clkout_r; // [R04]

endmodule // oscillator_config_decode

// ---- verif/osc_cfg_chk.sv ----
`timescale 1ns/1ps
module osc_cfg_chk
(
  // Clock, reset and bus
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Decoded controls
  input wire logic switch_enable,
  input wire logic monitor_enable,
  input wire logic sosc_high_power,
  input wire logic [1:0] primary_freq_range,
  input wire logic [1:0] primary_osc_mode,
  input wire logic clock_output_signal_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence wr_s;
    psel && penable && pwrite && paddr == osc_cfg_pkg::ADDR_CONFIG;
  endsequence
  switch_ctl_a: assert property (wr_s |-> ##2 switch_enable == !$past(pwdata[7], 2))
    else $error("switch decode wrong");
  monitor_ctl_a: assert property (wr_s |-> ##2 monitor_enable == ($past(pwdata[7:6], 2) == 2'h0))
    else $error("monitor decode wrong");
  sosc_power_a: assert property (wr_s |-> ##2 sosc_high_power == $past(pwdata[5], 2))
    else $error("sosc power wrong");
  freq_range_a: assert property (wr_s ##0 pwdata[4:3] != 2'h0 |-> ##2 primary_freq_range == $past(pwdata[4:3], 2))
    else $error("range decode wrong");
  range_hold_a: assert property (wr_s ##0 pwdata[4:3] == 2'h0 |-> ##2 $stable(primary_freq_range))
    else $error("reserved range not held");
  clk_out_a: assert property (wr_s |-> ##2 clock_output_signal_enable == ($past(pwdata[2:0], 2) inside {3'h7, 3'h4}))
    else $error("clock out wrong");
  osc_mode_a: assert property (wr_s |-> ##2 primary_osc_mode == $past(pwdata[1:0], 2))
    else $error("mode decode wrong");
  mon_needs_sw_a: assert property (monitor_enable |-> switch_enable)
    else $error("monitor without switch");
endmodule // osc_cfg_chk
bind oscillator_config_decode osc_cfg_chk chk (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .switch_enable, .monitor_enable, .sosc_high_power, .primary_freq_range, .primary_osc_mode,
  .clock_output_signal_enable);

// ---- verif/test_oscillator_config_decode.sv ----
`timescale 1ns/1ps
module test_oscillator_config_decode;
  logic clock = 0;
  logic reset_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sw, mon, sosc, clock_output_signal;
  logic [1:0] rng, mode;
  logic [40:0] keep;
  wire [40:0] obs = {pslverr, prdata, sw, mon, sosc, rng, mode, clock_output_signal};
  logic [1:0] last_rng = 2'h3;
  logic [7:0] cur = 8'hFF;
  logic [40:0] q[$];
  int miscompares = 0;
  int total_checks = 0;
  integer seed = 45386;
  oscillator_config_decode DUT (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .switch_enable(sw), .monitor_enable(mon), .sosc_high_power(sosc), .primary_freq_range(rng),
    .primary_osc_mode(mode), .clock_output_signal_enable(clock_output_signal));
  initial forever #12.5 clock = ~clock;
  task automatic check(logic [40:0] seen, logic [40:0] want);
    total_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reserved range code leaves the previous range in force
  function automatic logic [7:0] dec(logic [7:0] b);
    if (b[4:3] != 2'h0)
      last_rng = b[4:3];
    return {!b[7], b[7:6] == 2'h0, b[5], last_rng, b[1:0], b[2] && (b[1:0] inside {2'h3, 2'h0})};
  endfunction
  // Status word: mode 9:8, range 6:5, reserved 4, clock out 3, power 2, monitor 1, switch 0
  function automatic logic [31:0] stat(logic [7:0] b);
    return {22'h0, b[1:0], 1'b0, last_rng, b[4:3] == 2'h0,
      b[2] && (b[1:0] inside {2'h3, 2'h0}), b[5], b[7:6] == 2'h0, !b[7]};
  endfunction
  task automatic apb(logic wr, logic [7:0] a, logic [7:0] d, logic [40:0] e);
    @(posedge clock);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1;
    q.push_back(e);
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic put(logic [7:0] d);
    apb(1, 8'h00, d, 41'h0);
    cur = d;
    apb(0, 8'h00, 8'h00, {1'b0, 24'h0, d, dec(d)});
  endtask
  // Writes are judged on the error response only
  always @(posedge clock)
    if (psel && penable && pready && q.size() > 0)
    begin
      keep = pwrite ? {1'b1, 40'h0} : '1;
      check(obs & keep, q.pop_front() & keep);
    end
  initial
  begin
    repeat (3) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    apb(0, 8'h00, 8'h00, {1'b0, 24'h0, cur, dec(cur)});
    $display("reset value done");
    for (int i = 0; i < 32; i++)
      put({i[4:3], i[0], i[2:1], i[2], i[1:0]});
    $display("field sweep done");
    repeat (20) put(8'($random(seed)));
    $display("random done");
    put(8'h45);
    apb(0, 8'h04, 8'h00, {1'b0, stat(cur), dec(cur)});
    apb(1, 8'h04, 8'h12, {1'b1, 40'h0});
    apb(1, 8'h08, 8'h12, {1'b1, 40'h0});
    apb(0, 8'h08, 8'h00, {1'b1, 32'h0, dec(cur)});
    apb(0, 8'h00, 8'h00, {1'b0, 24'h0, cur, dec(cur)});
    $display("refusal done");
    @(posedge clock);
    reset_n <= 0;
    repeat (2) @(posedge clock);
    reset_n <= 1;
    cur = 8'hFF;
    @(posedge clock);
    apb(0, 8'h00, 8'h00, {1'b0, 24'h0, cur, dec(cur)});
    $display("second reset done");
    end_sim();
  end
  initial
  begin
    #50us;
    miscompares++;
    end_sim();
  end
endmodule // test_oscillator_config_decode
